// >>> include/asc_map.svh
// Purpose: register indexes, field positions, reset values of the converter control block
// Assumes: byte address of a register is four times its index
// Notes:   definitions only
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH

// register indexes
`define ASC_IDX_RESULT_A     16'hFF90
`define ASC_IDX_RESULT_B     16'hFF92
`define ASC_IDX_RESULT_C     16'hFF94
`define ASC_IDX_RESULT_D     16'hFF96
`define ASC_IDX_CTRL_STATUS  16'hFF98
`define ASC_IDX_TRIG_CTRL    16'hFF99
`define ASC_IDX_IRQ_STATUS   16'hFF9A
`define ASC_IDX_IRQ_MASK     16'hFF9B

// control/status fields
`define ASC_CS_END_FLAG      7
`define ASC_CS_IRQ_EN        6
`define ASC_CS_START         5
`define ASC_CS_SCAN          4
`define ASC_CS_CLK_SEL       3
`define ASC_CS_GROUP         2

// trigger control fields
`define ASC_TC_TRG_HI        7
`define ASC_TC_TRG_LO        6
`define ASC_TC_CLK_SEL1      3

// result layout
`define ASC_RES_LSB          6
`define ASC_RES_W            10

// reset values
`define ASC_RST_RESULT       10'h000
`define ASC_RST_CTRL_STATUS  8'h00
`define ASC_RST_TRIG_CTRL    8'h00
`define ASC_RST_IRQ          2'h0

// interrupt status bits
`define ASC_IRQ_CONV_END     0
`define ASC_IRQ_HW_START     1
`define ASC_IRQ_W            2

// bus responses
`define ASC_RESP_OKAY        2'h0
`define ASC_RESP_SLVERR      2'h2

`endif

// >>> include/asc_pkg.sv
// Purpose: shared types of the converter control block
// Assumes: nothing beyond the map header
// Notes:   constants live in asc_map.svh
package asc_pkg;

  typedef enum logic [1:0] {
    ASC_TRG_OFF,
    ASC_TRG_TIMER_PULSE,
    ASC_TRG_TIMER8,
    ASC_TRG_PIN
  } asc_trig_sel_t;

  typedef enum {
    ASC_ST_IDLE,
    ASC_ST_CONV
  } asc_seq_state_t;

  typedef logic [1:0] asc_resp_t;

endpackage

// >>> rtl/asc_adc_sequencer_control.sv
// Purpose: control, sequencing and result storage of an eight-input two-group converter
// Assumes: analog core takes a one-cycle start pulse and answers with a done pulse plus data
// Notes:   registers reached over AXI4-Lite; byte address is four times the register index
//
// Overview of operation
// RULE1 - four read-only result registers, 10-bit value in bits 15:6, low bits zero
// RULE2 - single mode: start bit converts one channel, cleared by hardware at completion
// RULE3 - scan mode: start bit converts selected channels in a loop until cleared
// RULE4 - scan stops on software zero write, reset, standby or module stop
// RULE5 - conversion-end interrupt requested while flag set and enable bit is one
// RULE6 - end flag only cleared by writing zero; writing one has no effect
// RULE7 - trigger field: 00 off, 01 timer pulse, 10 eight-bit timer, 11 pin
// RULE8 - group bit picks inputs 0-3 or 4-7; low bits pick channel or last
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "asc_map.svh"

module asc_adc_sequencer_control #(
  parameter int ADDR_W = 18
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                clk_en,
  // register bus
  input  wire logic                awvalid,
  output      logic                awready,
  input  wire logic [ADDR_W-1:0]   awaddr,
  input  wire logic                wvalid,
  output      logic                wready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  output      logic                bvalid,
  input  wire logic                bready,
  output      asc_pkg::asc_resp_t  bresp,
  input  wire logic                arvalid,
  output      logic                arready,
  input  wire logic [ADDR_W-1:0]   araddr,
  output      logic                rvalid,
  input  wire logic                rready,
  output      logic [31:0]         rdata,
  output      asc_pkg::asc_resp_t  rresp,
  // analog core
  output      logic                conv_start,
  output      logic [2:0]          conv_channel,
  output      logic                conv_clock_select,
  output      logic                conv_clock_select1,
  input  wire logic                conv_done,
  input  wire logic [9:0]          conv_data,
  // trigger sources and power states
  input  wire logic                timer_pulse_unit_trig,
  input  wire logic                timer8_trig,
  input  wire logic                external_trigger_pin_n,
  input  wire logic                standby_req,
  input  wire logic                module_stop,
  // interrupts
  output      logic                conv_end_irq,
  output      logic                irq
);
  import asc_pkg::*;

  // register fields: control/status, trigger control, results, interrupt status and mask
  logic                      end_flag_ff;
  logic                      irq_en_ff;
  logic                      start_ff;
  logic                      scan_ff;
  logic                      clk_sel_ff;
  logic [2:0]                chan_sel_ff;
  logic [7:0]                trig_ctrl_ff;
  logic [`ASC_RES_W-1:0]     result_ff [4];
  logic [`ASC_IRQ_W-1:0]     irq_status_ff;
  logic [`ASC_IRQ_W-1:0]     irq_mask_ff;

  // sequencer
  asc_seq_state_t            state_ff;
  logic [1:0]                cur_ch_ff;
  logic                      conv_start_ff;
  logic [2:0]                conv_channel_ff;

  // bus slave state
  logic                      aw_hold_ff;
  logic [ADDR_W-1:0]         aw_addr_ff;
  logic                      w_hold_ff;
  logic [31:0]               w_data_ff;
  logic [3:0]                w_strb_ff;
  logic                      bvalid_ff;
  asc_resp_t                 bresp_ff;
  logic                      rvalid_ff;
  logic [31:0]               rdata_ff;
  asc_resp_t                 rresp_ff;

  // pin synchroniser
  logic                      pin_s1_ff;
  logic                      pin_s2_ff;
  logic                      pin_s3_ff;
  logic                      pin_lvl_ff;

  // register index from a byte address
  function automatic logic [15:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = 16'(addr[ADDR_W-1:2]);
  endfunction

  // true when the index names a register of this block
  function automatic logic is_mapped(input logic [15:0] idx);
    if (idx == `ASC_IDX_RESULT_A || idx == `ASC_IDX_RESULT_B) begin
      is_mapped = 1'b1;
    end else if (idx == `ASC_IDX_RESULT_C || idx == `ASC_IDX_RESULT_D) begin
      is_mapped = 1'b1;
    end else if (idx == `ASC_IDX_CTRL_STATUS || idx == `ASC_IDX_TRIG_CTRL) begin
      is_mapped = 1'b1;
    end else if (idx == `ASC_IDX_IRQ_STATUS || idx == `ASC_IDX_IRQ_MASK) begin
      is_mapped = 1'b1;
    end else begin
      is_mapped = 1'b0;
    end
  endfunction

  // handshakes: ready only while the slot is free and the clock is enabled
  assign awready = clk_en & ~aw_hold_ff & ~bvalid_ff;
  assign wready  = clk_en & ~w_hold_ff & ~bvalid_ff;
  assign arready = clk_en & ~rvalid_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;

  // write commits once both address and data are held
  logic        do_write;
  logic [15:0] wr_idx;
  logic        wr_lane0;
  assign do_write = clk_en & aw_hold_ff & w_hold_ff & ~bvalid_ff;
  assign wr_idx   = reg_index(aw_addr_ff);
  assign wr_lane0 = do_write & w_strb_ff[0];

  logic wr_cs;
  logic wr_tc;
  logic wr_is;
  logic wr_im;
  assign wr_cs = wr_lane0 & (wr_idx == `ASC_IDX_CTRL_STATUS);
  assign wr_tc = wr_lane0 & (wr_idx == `ASC_IDX_TRIG_CTRL);
  assign wr_is = wr_lane0 & (wr_idx == `ASC_IDX_IRQ_STATUS);
  assign wr_im = wr_lane0 & (wr_idx == `ASC_IDX_IRQ_MASK);

  // address and data channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_hold_ff  <= 1'b0;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
    end else if (clk_en) begin
      if (awvalid && awready) begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= awaddr;
      end else if (do_write) begin
        aw_hold_ff <= 1'b0;
      end
      if (wvalid && wready) begin
        w_hold_ff <= 1'b1;
        w_data_ff <= wdata;
        w_strb_ff <= wstrb;
      end else if (do_write) begin
        w_hold_ff <= 1'b0;
      end
    end
  end

  // write response; read-only and unmapped targets answered without side effect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `ASC_RESP_OKAY;
    end else if (clk_en) begin
      if (do_write) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= is_mapped(wr_idx) ? `ASC_RESP_OKAY : `ASC_RESP_SLVERR;
      end else if (bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // read data mux
  function automatic logic [31:0] read_value(input logic [15:0] idx);
    if (idx == `ASC_IDX_RESULT_A) begin
      read_value = {16'h0000, result_ff[0], 6'h00}; // RULE1
    end else if (idx == `ASC_IDX_RESULT_B) begin
      read_value = {16'h0000, result_ff[1], 6'h00}; // RULE1
    end else if (idx == `ASC_IDX_RESULT_C) begin
      read_value = {16'h0000, result_ff[2], 6'h00}; // RULE1
    end else if (idx == `ASC_IDX_RESULT_D) begin
      read_value = {16'h0000, result_ff[3], 6'h00}; // RULE1
    end else if (idx == `ASC_IDX_CTRL_STATUS) begin
      read_value = {24'h000000, end_flag_ff, irq_en_ff, start_ff, scan_ff,
                    clk_sel_ff, chan_sel_ff};
    end else if (idx == `ASC_IDX_TRIG_CTRL) begin
      read_value = {24'h000000, trig_ctrl_ff};
    end else if (idx == `ASC_IDX_IRQ_STATUS) begin
      read_value = {30'h0000_0000, irq_status_ff};
    end else if (idx == `ASC_IDX_IRQ_MASK) begin
      read_value = {30'h0000_0000, irq_mask_ff};
    end else begin
      read_value = 32'h0000_0000;
    end
  endfunction

  // read channel: one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `ASC_RESP_OKAY;
    end else if (clk_en) begin
      if (arvalid && arready) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= read_value(reg_index(araddr));
        rresp_ff  <= is_mapped(reg_index(araddr)) ? `ASC_RESP_OKAY : `ASC_RESP_SLVERR;
      end else if (rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // trigger pin: three stages, level accepted once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_ff  <= 1'b1;
      pin_s2_ff  <= 1'b1;
      pin_s3_ff  <= 1'b1;
      pin_lvl_ff <= 1'b1;
    end else if (clk_en) begin
      pin_s1_ff <= external_trigger_pin_n;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      if (pin_s2_ff == pin_s3_ff) begin
        pin_lvl_ff <= pin_s3_ff;
      end
    end
  end

  // hardware start request from the selected source
  logic          pin_fall;
  logic          hw_trig;
  asc_trig_sel_t trig_sel;
  assign pin_fall = pin_lvl_ff & ~pin_s3_ff & (pin_s2_ff == pin_s3_ff);
  assign trig_sel = asc_trig_sel_t'({trig_ctrl_ff[`ASC_TC_TRG_HI], trig_ctrl_ff[`ASC_TC_TRG_LO]});
  always_comb begin
    case (trig_sel) // RULE7
      ASC_TRG_TIMER_PULSE: hw_trig = timer_pulse_unit_trig;
      ASC_TRG_TIMER8:      hw_trig = timer8_trig;
      ASC_TRG_PIN:         hw_trig = pin_fall;
      default:             hw_trig = 1'b0;
    endcase
  end

  // sequencer events
  logic stop_cond;
  logic done_take;
  logic last_ch;
  logic single_end;
  logic pass_end;
  logic trig_start;
  assign stop_cond  = standby_req | module_stop; // RULE4
  assign done_take  = (state_ff == ASC_ST_CONV) & conv_done & start_ff;
  assign last_ch    = (cur_ch_ff == chan_sel_ff[1:0]);
  assign single_end = done_take & ~scan_ff; // RULE2
  assign pass_end   = done_take & scan_ff & last_ch; // RULE3
  assign trig_start = hw_trig & ~start_ff & ~stop_cond;

  // start bit: stop states beat software, software beats hardware clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_ff <= 1'b0;
    end else if (clk_en) begin
      if (stop_cond) begin
        start_ff <= 1'b0; // RULE4
      end else if (wr_cs) begin
        start_ff <= w_data_ff[`ASC_CS_START]; // RULE4
      end else if (single_end) begin
        start_ff <= 1'b0; // RULE2
      end else if (trig_start) begin
        start_ff <= 1'b1; // RULE7
      end
    end
  end

  // plain read/write control fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_ff    <= 1'(`ASC_RST_CTRL_STATUS >> `ASC_CS_IRQ_EN);
      scan_ff      <= 1'b0;
      clk_sel_ff   <= 1'b0;
      chan_sel_ff  <= 3'h0;
      trig_ctrl_ff <= `ASC_RST_TRIG_CTRL;
    end else if (clk_en) begin
      if (wr_cs) begin
        irq_en_ff   <= w_data_ff[`ASC_CS_IRQ_EN];
        scan_ff     <= w_data_ff[`ASC_CS_SCAN];
        clk_sel_ff  <= w_data_ff[`ASC_CS_CLK_SEL];
        chan_sel_ff <= w_data_ff[`ASC_CS_GROUP:0];
      end
      if (wr_tc) begin
        trig_ctrl_ff <= w_data_ff[7:0];
      end
    end
  end

  // end flag: set wins over a clearing write, a written one is ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      end_flag_ff <= 1'b0;
    end else if (clk_en) begin
      if (single_end || pass_end) begin
        end_flag_ff <= 1'b1;
      end else if (wr_cs && !w_data_ff[`ASC_CS_END_FLAG]) begin
        end_flag_ff <= 1'b0; // RULE6
      end
    end
  end

  // conversion sequencer; abandons an in-flight conversion once the start bit drops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff        <= ASC_ST_IDLE;
      cur_ch_ff       <= 2'h0;
      conv_start_ff   <= 1'b0;
      conv_channel_ff <= 3'h0;
    end else if (clk_en) begin
      conv_start_ff <= 1'b0;
      case (state_ff)
        ASC_ST_IDLE: begin
          if (start_ff && !stop_cond) begin
            // scan begins at the group's first input, single uses the chosen one
            cur_ch_ff       <= scan_ff ? 2'h0 : chan_sel_ff[1:0]; // RULE8
            conv_channel_ff <= {chan_sel_ff[2], scan_ff ? 2'h0 : chan_sel_ff[1:0]}; // RULE8
            conv_start_ff   <= 1'b1;
            state_ff        <= ASC_ST_CONV;
          end
        end
        ASC_ST_CONV: begin
          if (!start_ff) begin
            state_ff <= ASC_ST_IDLE; // RULE3
          end else if (conv_done) begin
            if (!scan_ff) begin
              state_ff <= ASC_ST_IDLE; // RULE2
            end else begin
              // wrap after the last selected input and keep going
              cur_ch_ff       <= last_ch ? 2'h0 : cur_ch_ff + 2'h1; // RULE3
              conv_channel_ff <= {chan_sel_ff[2], last_ch ? 2'h0 : cur_ch_ff + 2'h1}; // RULE8
              conv_start_ff   <= 1'b1;
            end
          end
        end
        default: state_ff <= ASC_ST_IDLE;
      endcase
    end
  end

  // results land in the register paired with the input's position in its group
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) begin
        result_ff[i] <= `ASC_RST_RESULT; // RULE1
      end
    end else if (clk_en && done_take) begin
      result_ff[cur_ch_ff] <= conv_data; // RULE8
    end
  end

  // sticky event bits, write one to clear, a new event wins
  logic [`ASC_IRQ_W-1:0] irq_set;
  assign irq_set = {trig_start, single_end | pass_end};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_ff <= `ASC_RST_IRQ;
      irq_mask_ff   <= `ASC_RST_IRQ;
    end else if (clk_en) begin
      irq_status_ff <= irq_set | (irq_status_ff & ~(wr_is ? w_data_ff[1:0] : 2'h0));
      if (wr_im) begin
        irq_mask_ff <= w_data_ff[1:0];
      end
    end
  end

  // analog-side and interrupt outputs
  assign conv_start         = conv_start_ff;
  assign conv_channel       = conv_channel_ff;
  assign conv_clock_select  = clk_sel_ff;
  assign conv_clock_select1 = trig_ctrl_ff[`ASC_TC_CLK_SEL1];
  assign conv_end_irq       = end_flag_ff & irq_en_ff; // RULE5
  assign irq                = |(irq_status_ff & irq_mask_ff);

endmodule

// >>> tb/asc_analog_model.sv
// Purpose: behavioural analog core answering each start with one done
// Assumes: start is a one-cycle pulse on the design clock
// Notes:   data line toggles outside the done cycle so stale values never pass
`timescale 1ns/1ns
module asc_analog_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       conv_start,
  input  wire logic [2:0] conv_channel,
  input  wire logic       slow,
  output      logic       conv_done,
  output      logic [9:0] conv_data
);
  logic [3:0] wait_ff;
  logic       busy_ff;
  logic [2:0] ch_ff;
  // one done per start, two cycles after the start pulse or seven when slow
  always_ff @(posedge aclk) begin
    conv_done <= 1'h0;
    conv_data <= ~conv_data;
    if (!aresetn) begin
      busy_ff   <= 1'h0;
      conv_data <= 10'h155;
    end else if (conv_start) begin
      busy_ff <= 1'h1;
      ch_ff   <= conv_channel;
      wait_ff <= slow ? 4'h6 : 4'h1;
    end else if (busy_ff) begin
      wait_ff <= wait_ff - 4'h1;
      if (wait_ff == 4'h1) begin
        busy_ff   <= 1'h0;
        conv_done <= 1'h1;
        conv_data <= {ch_ff, 7'h35};
      end
    end
  end
endmodule

// >>> tb/asc_adc_sequencer_control_checker.sv
// Purpose: port-level assertions of the converter control block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound into the design top at the foot of this file
`timescale 1ns/1ns
`include "asc_map.svh"
module asc_adc_sequencer_control_checker #(
  parameter int ADDR_W = 18
) (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               awready,
  input wire logic               wready,
  input wire logic               bvalid,
  input wire logic               bready,
  input wire asc_pkg::asc_resp_t bresp,
  input wire logic               arvalid,
  input wire logic               arready,
  input wire logic [ADDR_W-1:0]  araddr,
  input wire logic               rvalid,
  input wire logic               rready,
  input wire logic [31:0]        rdata,
  input wire logic               conv_start,
  input wire logic               conv_done,
  input wire logic               standby_req,
  input wire logic               module_stop,
  input wire logic               conv_end_irq
);
  import asc_pkg::*;
  logic res_rd_ff;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // remember whether the read in flight targets a result word
  always_ff @(posedge aclk) begin
    if (!aresetn)
      res_rd_ff <= 1'h0;
    else if (arvalid && arready)
      res_rd_ff <= araddr[ADDR_W-1:2] >= `ASC_IDX_RESULT_A
                   && araddr[ADDR_W-1:2] <= `ASC_IDX_RESULT_D && !araddr[2];
  end
  AST_RES_LAYOUT: assert property (rvalid && res_rd_ff |-> rdata[5:0] == 6'h00
    && rdata[31:16] == 16'h0000) else $error("result word has bits outside 15:6");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response not held");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  AST_W_BLOCK: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  AST_START_PULSE: assert property (conv_start |=> !conv_start)
    else $error("start pulse longer than one cycle");
  AST_STOP_NO_START: assert property ((standby_req || module_stop) [*3] |-> !conv_start)
    else $error("conversion started while stopped");
  AST_IRQ_RISE: assert property ($rose(conv_end_irq) |-> $past(conv_done) || $rose(bvalid))
    else $error("end interrupt rose without cause");
  AST_IRQ_FALL: assert property ($fell(conv_end_irq) |-> $rose(bvalid))
    else $error("end interrupt fell without a write");
endmodule

bind asc_adc_sequencer_control asc_adc_sequencer_control_checker #(.ADDR_W(ADDR_W)) u_chk (
  .aclk, .aresetn, .awready, .wready, .bvalid, .bready, .bresp, .arvalid, .arready,
  .araddr, .rvalid, .rready, .rdata, .conv_start, .conv_done, .standby_req, .module_stop,
  .conv_end_irq);

// >>> tb/asc_adc_sequencer_control_tb_top.sv
// Purpose: self-checking bench of the converter control block
// Assumes: partner model answers each start with exactly one done
// Notes:   registers reached through AXI4-Lite tasks; byte address is index times four
`timescale 1ns/1ns
`include "asc_map.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("BAD %0t got %0h exp %0h", $time, (a), (b)); end end

module asc_adc_sequencer_control_tb_top;
  import asc_pkg::*;
  localparam logic [15:0] CS = `ASC_IDX_CTRL_STATUS;
  logic        aclk = 1'h0, aresetn = 1'h0, clk_en = 1'h1, slow = 1'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [17:0] awaddr = 18'h00000, araddr = 18'h00000;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] rdata, d;
  logic [3:0]  wstrb = 4'hF;
  logic        awready, wready, bvalid, arready, rvalid, conv_start, conv_done;
  logic        conv_end_irq, irq, conv_clock_select, conv_clock_select1;
  logic [2:0]  conv_channel;
  logic [9:0]  conv_data;
  asc_resp_t   bresp, rresp, r;
  logic        timer_pulse_unit_trig = 1'h0, timer8_trig = 1'h0, external_trigger_pin_n = 1'h1;
  logic        standby_req = 1'h0, module_stop = 1'h0;
  int          mismatches = 0, n_checks = 0;

  asc_adc_sequencer_control #(.ADDR_W(18)) dut (.aclk, .aresetn, .clk_en, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp, .conv_start, .conv_channel, .conv_clock_select,
    .conv_clock_select1, .conv_done, .conv_data, .timer_pulse_unit_trig, .timer8_trig,
    .external_trigger_pin_n, .standby_req, .module_stop, .conv_end_irq, .irq);
  asc_analog_model u_core (.aclk, .aresetn, .conv_start, .conv_channel, .slow, .conv_done,
    .conv_data);

  // 50 ns clock
  always #25 aclk = ~aclk;

  // one write; address and data released as each is taken
  // bready comes late on purpose so the response must be held for a cycle
  task automatic wr(input logic [15:0] idx, input logic [31:0] v);
    @(posedge aclk);
    awvalid <= 1'h1;
    awaddr  <= {idx, 2'h0};
    wvalid  <= 1'h1;
    wdata   <= v;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h1;
    @(posedge aclk);
    r = bresp;
    bready <= 1'h0;
  endtask

  // one read into d and r; rready late so read data must stand
  task automatic rd(input logic [15:0] idx);
    @(posedge aclk);
    arvalid <= 1'h1;
    araddr  <= {idx, 2'h0};
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h1;
    @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask

  // poll the end flag, bounded
  task automatic wait_flag;
    for (int i = 0; i < 60; i++) begin
      rd(CS);
      if (d[7] === 1'h1) break;
    end
  endtask

  // single conversion of one input, irq enable as given
  task automatic conv1(input logic [2:0] ch, input logic ie);
    wr(CS, {24'h000000, 1'h0, ie, 1'h1, 2'h0, ch});
    wait_flag;
  endtask

  // one source fires: timers pulse one cycle, pin goes low for seven
  task automatic pulse(input int s);
    @(posedge aclk);
    timer_pulse_unit_trig  <= (s == 1);
    timer8_trig            <= (s == 2);
    external_trigger_pin_n <= (s != 3);
    @(posedge aclk);
    timer_pulse_unit_trig <= 1'h0;
    timer8_trig           <= 1'h0;
    repeat (6) @(posedge aclk);
    external_trigger_pin_n <= 1'h1;
    repeat (20) @(posedge aclk);
  endtask

  // reset values and decode of every index in the block
  task automatic t_regs;
    for (int k = 16'hFF90; k <= 16'hFF9B; k++) begin
      rd(k[15:0]);
      `CHK(r, (k < 16'hFF98 && k[0]) ? `ASC_RESP_SLVERR : `ASC_RESP_OKAY);
      if (r === `ASC_RESP_OKAY) `CHK(d, 32'h00000000);
    end
    wr(`ASC_IDX_RESULT_A, 32'h0000FFC0);
    `CHK(r, `ASC_RESP_OKAY);
    wr(16'hFF91, 32'h000000FF);
    `CHK(r, `ASC_RESP_SLVERR);
    wr(CS, 32'h00000008);
    `CHK(conv_clock_select, 1'h1);
    wr(CS, 32'h00000000);
    `CHK(conv_clock_select, 1'h0);
    rd(`ASC_IDX_RESULT_A);
    `CHK(d, 32'h00000000);
  endtask

  // every input once, fast and slow core; flag write of one is ignored
  task automatic t_single;
    for (int c = 0; c < 8; c++) begin
      slow <= c[0];
      conv1(c[2:0], 1'h0);
      `CHK(d[7:5], 3'h4);
      rd({12'hFF9, 1'h0, c[1:0], 1'h0});
      `CHK(d, {16'h0000, c[2:0], 7'h35, 6'h00});
      wr(CS, 32'h00000080);
      rd(CS);
      `CHK(d[7], 1'h1);
      wr(CS, 32'h00000000);
      rd(CS);
      `CHK(d[7], 1'h0);
    end
  endtask

  // end interrupt with enable, then the status/mask pair, then without enable
  task automatic t_irq;
    conv1(3'h2, 1'h1);
    `CHK(conv_end_irq, 1'h1);
    wr(CS, 32'h00000040);
    `CHK(conv_end_irq, 1'h0);
    wr(`ASC_IDX_IRQ_MASK, 32'h00000001);
    `CHK(irq, 1'h1);
    wr(`ASC_IDX_IRQ_STATUS, 32'h00000003);
    `CHK(irq, 1'h0);
    conv1(3'h2, 1'h0);
    `CHK({irq, conv_end_irq}, 2'h2);
    wr(CS, 32'h000000C0);
    `CHK(conv_end_irq, 1'h1);
    wr(CS, 32'h00000000);
    wr(`ASC_IDX_IRQ_STATUS, 32'h00000003);
  endtask

  // scan of inputs 4 and 5, stopped by software, standby and module stop
  task automatic t_scan;
    int n;
    wr(CS, 32'h00000035);
    wait_flag;
    `CHK(d[5], 1'h1);
    wr(CS, 32'h00000035);
    wait_flag;
    `CHK(d[7:5], 3'h5);
    rd(`ASC_IDX_RESULT_B);
    `CHK(d, {16'h0000, 3'h5, 7'h35, 6'h00});
    wr(CS, 32'h00000015);
    n = 0;
    repeat (3) @(posedge aclk);
    repeat (20) begin
      @(posedge aclk);
      if (conv_start !== 1'h0) n++;
    end
    `CHK(n, 0);
    for (int s = 0; s < 2; s++) begin
      wr(CS, 32'h00000035);
      standby_req <= s[0];
      module_stop <= !s[0];
      repeat (4) @(posedge aclk);
      rd(CS);
      `CHK(d[5], 1'h0);
      standby_req <= 1'h0;
      module_stop <= 1'h0;
      wr(CS, 32'h00000000);
    end
  endtask

  // every trigger code against every source
  task automatic t_trig;
    for (int t = 0; t < 4; t++) begin
      wr(`ASC_IDX_TRIG_CTRL, {24'h000000, t[1:0], 6'h08});
      rd(`ASC_IDX_TRIG_CTRL);
      `CHK(d, {24'h000000, t[1:0], 6'h08});
      `CHK(conv_clock_select1, 1'h1);
      for (int s = 1; s < 4; s++) begin
        pulse(s);
        rd(CS);
        `CHK(d[7], s == t);
        wr(CS, 32'h00000000);
      end
    end
    wr(`ASC_IDX_TRIG_CTRL, 32'h00000000);
  endtask

  // counts, verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // main sequence after two reset cycles
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs;
    t_single;
    t_irq;
    t_scan;
    t_trig;
    complete_run;
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (30000) @(posedge aclk);
    mismatches++;
    complete_run;
  end
endmodule
